// *** hdl/sclk_pkg.sv ***
// Package with register map, field layout, mode codes and timing constants for the clocking-mode block.
package sclk_pkg;

  // Register offsets (byte offsets on the plain register port).
  localparam logic [7:0] SCLK_OFS_MODE_SEL = 8'h03;
  localparam logic [7:0] SCLK_OFS_FMT_OVR = 8'h04;
  localparam logic [7:0] SCLK_OFS_OSC_CTRL = 8'h05;
  localparam logic [7:0] SCLK_OFS_PLL_M = 8'h06;
  localparam logic [7:0] SCLK_OFS_PLL_N = 8'h07;
  localparam logic [7:0] SCLK_OFS_LV_CFG = 8'h10;
  localparam logic [7:0] SCLK_OFS_DT_MATCH = 8'h11;
  localparam logic [7:0] SCLK_OFS_STATUS = 8'h20;

  // Field positions.
  localparam int SCLK_MODE_LSB = 0;
  localparam int SCLK_MODE_W = 3;
  localparam int SCLK_OVR_EN_BIT = 4;
  localparam int SCLK_OSC_SEL_BIT = 3;
  localparam int SCLK_IN_DIV_BIT = 0;
  localparam int SCLK_HSDIV_LSB = 6;
  localparam int SCLK_DT_MATCH_EN_BIT = 7;
  localparam int SCLK_FMT_OVR_EN_BIT = 1;
  localparam int SCLK_FMT_12_BIT = 0;

  // Reset values.
  localparam logic [7:0] SCLK_RST_FMT_OVR = 8'h00;
  localparam logic [7:0] SCLK_RST_OSC_CTRL = 8'h00;
  localparam logic [7:0] SCLK_RST_PLL_M = 8'h01;
  localparam logic [7:0] SCLK_RST_PLL_N = 8'h01;
  localparam logic [7:0] SCLK_RST_LV_CFG = 8'h00;
  localparam logic [7:0] SCLK_RST_DT_MATCH = 8'h00;
  localparam logic [1:0] SCLK_RST_HSDIV = 2'h0;

  // Clocking mode codes.
  localparam logic [2:0] SCLK_MODE_SYNC = 3'h0;
  localparam logic [2:0] SCLK_MODE_EXT = 3'h2;
  localparam logic [2:0] SCLK_MODE_INT = 3'h3;
  localparam logic [2:0] SCLK_MODE_LEGACY = 3'h5;

  // Forward-rate multipliers per reference.
  localparam logic [7:0] SCLK_MUL_SYNC = 8'hA0;
  localparam logic [7:0] SCLK_MUL_80 = 8'h50;
  localparam logic [7:0] SCLK_MUL_40 = 8'h28;
  localparam logic [7:0] SCLK_MUL_LEGACY = 8'h1C;
  // Camera-port bandwidth ceilings as multiples of the reference.
  localparam logic [7:0] SCLK_BW_SYNC = 8'h80;
  localparam logic [7:0] SCLK_BW_64 = 8'h40;
  localparam logic [7:0] SCLK_BW_32 = 8'h20;
  localparam logic [7:0] SCLK_BW_LEGACY = 8'h14;

  // Internal oscillator range in kHz.
  localparam int SCLK_OSC_MIN_KHZ = 24200;
  localparam int SCLK_OSC_MAX_KHZ = 25500;
  // System clock period in ns and the power-down debounce time.
  localparam int SCLK_SYS_PERIOD_NS = 100;
  localparam int SCLK_PWRDN_SETTLE_NS = 300;
  localparam int SCLK_PWRDN_SETTLE_CYC = (SCLK_PWRDN_SETTLE_NS + SCLK_SYS_PERIOD_NS - 1) / SCLK_SYS_PERIOD_NS;

  // Reference clock source selector.
  typedef enum logic [1:0] {
    SCLK_SRC_BACK_CHANNEL,
    SCLK_SRC_EXT_CLOCK,
    SCLK_SRC_OSCILLATOR
  } sclk_src_t;

  // Register-port request.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sclk_req_t;

  // Clock plan handed to the analog PLLs and link.
  typedef struct packed {
    sclk_src_t src;
    logic [7:0] fwd_mul;
    logic [7:0] bw_mul;
    logic in_div2;
    logic osc_fast;
  } sclk_plan_t;

endpackage

// *** hdl/sclk_frac_div.sv ***
// Fractional divider that makes the sensor clock from the forward-rate tick stream.
`timescale 1ns/1ps
module sclk_frac_div
  import sclk_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic fc_tick,
  input wire logic enable,
  input wire logic [W-1:0] mul_m,
  input wire logic [W-1:0] div_n,
  input wire logic [4:0] hs_div,
  output logic clk_out,
  output logic exact_ratio
);

  // Phase accumulator for the M/N step; one bit wider to hold the carry.
  logic [W:0] acc_q;
  logic [W:0] acc_d;
  // Counter of M/N carries toward the high-speed divider.
  logic [4:0] hs_cnt_q;
  logic hs_wrap;
  logic step;

  // The accumulator adds M per tick and emits a step when it reaches N.
  always_comb begin
    acc_d = acc_q + {1'b0, mul_m};
    step = 1'b0;
    if (acc_d >= {1'b0, div_n}) begin
      acc_d = acc_d - {1'b0, div_n};
      step = 1'b1;
    end
  end

  // Half the high-speed divide per output phase gives a square wave.
  assign hs_wrap = step && (hs_cnt_q >= ((hs_div >> 1) - 5'h01));

  // Accumulator process; an N of zero would step on every tick, and the accumulator is held at zero.
  always_ff @(posedge sys_clk) begin
    if (srst || !enable || div_n == '0) begin
      acc_q <= '0;
    end else if (fc_tick) begin
      acc_q <= acc_d;
    end
  end

  // Phase counter inside one output half period.
  always_ff @(posedge sys_clk) begin
    if (srst || !enable) begin
      hs_cnt_q <= 5'h00;
    end else if (fc_tick && step) begin
      hs_cnt_q <= hs_wrap ? 5'h00 : hs_cnt_q + 5'h01;
    end
  end

  // Output toggles on every half period and is parked low when disabled.
  always_ff @(posedge sys_clk) begin
    if (srst || !enable) begin
      clk_out <= 1'b0;
    end else if (fc_tick && hs_wrap) begin
      clk_out <= ~clk_out;
    end
  end

  // Integer N/M keeps the accumulator free of residue, so jitter stays low.
  always_ff @(posedge sys_clk) begin
    if (srst || mul_m == '0) begin
      exact_ratio <= 1'b0;
    end else begin
      exact_ratio <= (div_n % mul_m) == '0;
    end
  end

endmodule

// *** hdl/sclk_mode_ctrl.sv ***
// Clocking-mode selection, strap latch, register file and sensor clock generation.
`timescale 1ns/1ps
module sclk_mode_ctrl
  import sclk_pkg::*;
#(
  parameter int DW = 8
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DW-1:0] reg_rdata,
  input wire logic power_down_pin,
  input wire logic [2:0] mode_strap,
  input wire logic fc_tick,
  input wire logic [1:0] sensor_format,
  input wire logic [5:0] pkt_data_type,
  input wire logic pkt_valid,
  output logic pkt_accept,
  output logic pkt_reject,
  output sclk_plan_t clock_plan,
  output logic sensor_clk_out,
  output logic sensor_clk_en
);

  // Sensor format codes seen on the camera port.
  localparam logic [1:0] FMT_TEN = 2'h0;
  localparam logic [1:0] FMT_TWELVE_HF = 2'h1;
  localparam logic [1:0] FMT_TWELVE_LF = 2'h2;

  // Bundled register request.
  sclk_req_t req;
  // Mode field and its writable-override bit.
  logic [2:0] mode_q;
  logic ovr_en_q;
  // Power-down pin history for rising-edge detection and settle counter.
  logic pwrdn_q;
  logic [3:0] settle_q;
  logic settle_busy;
  // Plain software registers.
  logic [7:0] fmt_ovr_q;
  logic [7:0] osc_ctrl_q;
  logic [7:0] pll_m_q;
  logic [7:0] pll_n_q;
  logic [7:0] lv_cfg_q;
  logic [7:0] dt_match_q;
  // Decoded output divider value.
  logic [4:0] hs_div;
  logic exact_ratio;
  // Last packet outcome, kept for status readback.
  logic last_reject_q;
  // Effective format inside legacy mode.
  logic [1:0] eff_format;
  logic legacy;
  logic wr_mode;

  assign req = '{addr: reg_addr, wdata: reg_wdata[7:0], wr: reg_wr, rd: reg_rd};
  assign legacy = (mode_q == SCLK_MODE_LEGACY);
  assign wr_mode = req.wr && (req.addr == SCLK_OFS_MODE_SEL);
  assign settle_busy = (settle_q != 4'h0);

  // Power-down pin history; the pin is taken as synchronous to sys_clk.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pwrdn_q <= 1'b0;
    end else begin
      pwrdn_q <= power_down_pin;
    end
  end

  // A short settle window after release lets the strap level come to rest before it is caught.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      settle_q <= 4'h0;
    end else if (power_down_pin && !pwrdn_q) begin
      settle_q <= 4'(SCLK_PWRDN_SETTLE_CYC);
    end else if (settle_busy) begin
      settle_q <= settle_q - 4'h1;
    end
  end

  // Mode field: strap caught as the settle window after release ends, replaced only by software under override.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mode_q <= SCLK_MODE_SYNC;
    end else if (settle_q == 4'h1) begin
      mode_q <= mode_strap;
    end else if (wr_mode && ovr_en_q) begin
      mode_q <= req.wdata[SCLK_MODE_LSB +: SCLK_MODE_W];
    end
    // Without override a write leaves the field untouched.
  end

  // Override-enable bit of the mode-select register.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ovr_en_q <= 1'b0;
    end else if (wr_mode) begin
      ovr_en_q <= req.wdata[SCLK_OVR_EN_BIT];
    end
  end

  // Plain read-write registers, one address each.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      fmt_ovr_q <= SCLK_RST_FMT_OVR;
      osc_ctrl_q <= SCLK_RST_OSC_CTRL;
      pll_m_q <= SCLK_RST_PLL_M;
      pll_n_q <= SCLK_RST_PLL_N;
      lv_cfg_q <= SCLK_RST_LV_CFG;
      dt_match_q <= SCLK_RST_DT_MATCH;
    end else if (req.wr) begin
      if (req.addr == SCLK_OFS_FMT_OVR) begin
        fmt_ovr_q <= req.wdata;
      end else if (req.addr == SCLK_OFS_OSC_CTRL) begin
        osc_ctrl_q <= req.wdata;
      end else if (req.addr == SCLK_OFS_PLL_M) begin
        pll_m_q <= req.wdata;
      end else if (req.addr == SCLK_OFS_PLL_N) begin
        pll_n_q <= req.wdata;
      end else if (req.addr == SCLK_OFS_LV_CFG) begin
        lv_cfg_q <= req.wdata;
      end else if (req.addr == SCLK_OFS_DT_MATCH) begin
        dt_match_q <= req.wdata;
      end
    end
  end

  // Output divider code: 0 selects 4 (default), 1 selects 8, 2 or 3 select 16.
  always_comb begin
    case (pll_m_q[SCLK_HSDIV_LSB +: 2])
      2'h0: hs_div = 5'h04;
      2'h1: hs_div = 5'h08;
      default: hs_div = 5'h10;
    endcase
  end

  // Clock plan follows the mode field directly, so the source tracks every change.
  always_comb begin
    clock_plan = '{src: SCLK_SRC_BACK_CHANNEL, fwd_mul: SCLK_MUL_SYNC, bw_mul: SCLK_BW_SYNC,
                   in_div2: 1'b0, osc_fast: 1'b0};
    case (mode_q)
      SCLK_MODE_SYNC: begin
        clock_plan.src = SCLK_SRC_BACK_CHANNEL;
      end
      SCLK_MODE_EXT: begin
        clock_plan.src = SCLK_SRC_EXT_CLOCK;
        clock_plan.in_div2 = osc_ctrl_q[SCLK_IN_DIV_BIT];
        clock_plan.fwd_mul = clock_plan.in_div2 ? SCLK_MUL_40 : SCLK_MUL_80;
        clock_plan.bw_mul = clock_plan.in_div2 ? SCLK_BW_32 : SCLK_BW_64;
      end
      SCLK_MODE_INT: begin
        clock_plan.src = SCLK_SRC_OSCILLATOR;
        clock_plan.fwd_mul = SCLK_MUL_80;
        clock_plan.bw_mul = SCLK_BW_64;
        clock_plan.osc_fast = osc_ctrl_q[SCLK_OSC_SEL_BIT];
      end
      SCLK_MODE_LEGACY: begin
        clock_plan.src = SCLK_SRC_EXT_CLOCK;
        clock_plan.fwd_mul = SCLK_MUL_LEGACY;
        clock_plan.bw_mul = SCLK_BW_LEGACY;
      end
      default: begin
        clock_plan.src = SCLK_SRC_BACK_CHANNEL;
      end
    endcase
  end

  // The sensor clock runs in all modes except the oscillator mode, and is held off while the strap settle window runs.
  assign sensor_clk_en = (mode_q != SCLK_MODE_INT) && !settle_busy;

  // Fractional divider from the forward-rate ticks.
  sclk_frac_div #(
    .W(8)
  ) u_frac_div (
    .sys_clk(sys_clk),
    .srst(srst),
    .fc_tick(fc_tick),
    .enable(sensor_clk_en),
    .mul_m({2'h0, pll_m_q[5:0]}),
    .div_n(pll_n_q),
    .hs_div(hs_div),
    .clk_out(sensor_clk_out),
    .exact_ratio(exact_ratio)
  );

  // Legacy format: override register picks 10 or 12 bits, else the sensor's own format.
  always_comb begin
    eff_format = sensor_format;
    if (fmt_ovr_q[SCLK_FMT_OVR_EN_BIT]) begin
      eff_format = fmt_ovr_q[SCLK_FMT_12_BIT] ? FMT_TWELVE_HF : FMT_TEN;
    end
  end

  // Packet filter; outside legacy mode every packet passes.
  always_comb begin
    pkt_accept = 1'b0;
    pkt_reject = 1'b0;
    if (pkt_valid) begin
      if (!legacy) begin
        pkt_accept = 1'b1;
      end else if (dt_match_q[SCLK_DT_MATCH_EN_BIT] && pkt_data_type == dt_match_q[5:0]) begin
        pkt_accept = 1'b1;
      end else if (eff_format == FMT_TWELVE_LF || eff_format == 2'h3) begin
        pkt_reject = 1'b1;
      end else begin
        pkt_accept = 1'b1;
      end
    end
  end

  // Sticky copy of the latest packet verdict for software.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      last_reject_q <= 1'b0;
    end else if (pkt_valid) begin
      last_reject_q <= pkt_reject;
    end
  end

  // Read data register; unmapped addresses read zero.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata <= '0;
    end else if (req.rd) begin
      reg_rdata <= '0;
      if (req.addr == SCLK_OFS_MODE_SEL) begin
        reg_rdata[7:0] <= {3'h0, ovr_en_q, 1'b0, mode_q};
      end else if (req.addr == SCLK_OFS_FMT_OVR) begin
        reg_rdata[7:0] <= fmt_ovr_q;
      end else if (req.addr == SCLK_OFS_OSC_CTRL) begin
        reg_rdata[7:0] <= osc_ctrl_q;
      end else if (req.addr == SCLK_OFS_PLL_M) begin
        reg_rdata[7:0] <= pll_m_q;
      end else if (req.addr == SCLK_OFS_PLL_N) begin
        reg_rdata[7:0] <= pll_n_q;
      end else if (req.addr == SCLK_OFS_LV_CFG) begin
        reg_rdata[7:0] <= lv_cfg_q;
      end else if (req.addr == SCLK_OFS_DT_MATCH) begin
        reg_rdata[7:0] <= dt_match_q;
      end else if (req.addr == SCLK_OFS_STATUS) begin
        reg_rdata[7:0] <= {4'h0, last_reject_q, exact_ratio, sensor_clk_en, settle_busy};
      end
    end
  end

  // Sensor throughput limit is the sensor's duty; bw_mul reports the ceiling only.

endmodule

// *** bench/sclk_link_peer.sv ***
// Far-side link peer that supplies the forward-rate tick stream.
`timescale 1ns/1ps
module sclk_link_peer (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [3:0] gap,
  output logic fc_tick
);
  // Tick spacing counter; a slow peer is modelled by a larger gap.
  logic [3:0] cnt_q;

  // One pulse every gap cycles, as the recovered reference would give.
  always_ff @(posedge sys_clk) begin
    if (srst || cnt_q >= gap - 4'h1) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
  assign fc_tick = !srst && (cnt_q == 4'h0);
endmodule

// *** bench/sclk_mode_props.sv ***
// Checker for the clocking-mode block, seen from its ports.
`timescale 1ns/1ps
module sclk_mode_props
  import sclk_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic power_down_pin,
  input wire logic pkt_valid,
  input wire logic pkt_accept,
  input wire sclk_plan_t clock_plan,
  input wire logic sensor_clk_en
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  // The sensor clock stays off through the strap settle window.
  sequence s_hold_off;
    !sensor_clk_en [*3];
  endsequence

  a_osc_no_clkout: assert property (clock_plan.src == SCLK_SRC_OSCILLATOR |-> !sensor_clk_en)
    else $error("sensor clock enabled in oscillator mode");
  a_sync_rates: assert property (clock_plan.src == SCLK_SRC_BACK_CHANNEL |->
    clock_plan.fwd_mul == 8'hA0 && clock_plan.bw_mul == 8'h80)
    else $error("wrong rates on back-channel reference");
  a_osc_rate: assert property (clock_plan.src == SCLK_SRC_OSCILLATOR |-> clock_plan.fwd_mul == 8'h50)
    else $error("wrong rate on oscillator reference");
  a_ext_rates: assert property (clock_plan.src == SCLK_SRC_EXT_CLOCK |->
    clock_plan.fwd_mul inside {8'h50, 8'h28, 8'h1C})
    else $error("external reference with unknown rate");
  a_div_two: assert property (clock_plan.fwd_mul == 8'h28 |-> clock_plan.in_div2 && clock_plan.bw_mul == 8'h20)
    else $error("half rate without input divider");
  a_legacy_bw: assert property (clock_plan.fwd_mul == 8'h1C |->
    clock_plan.bw_mul == 8'h14 && clock_plan.src == SCLK_SRC_EXT_CLOCK)
    else $error("legacy rate with wrong bandwidth");
  a_strap_settle: assert property ($rose(power_down_pin) |=> s_hold_off)
    else $error("sensor clock not held off while strap settles");
  a_mode_readback: assert property (reg_rd && reg_addr == SCLK_OFS_MODE_SEL |=>
    (reg_rdata[2:0] == SCLK_MODE_INT) == ($past(clock_plan.src) == SCLK_SRC_OSCILLATOR))
    else $error("mode field disagrees with reference source");
  a_pkt_plain: assert property (pkt_valid && clock_plan.fwd_mul != 8'h1C |-> pkt_accept)
    else $error("packet refused outside legacy mode");
  a_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data moved without a read");
endmodule

// *** bench/sclk_tb.sv ***
// Self-checking testbench for the clocking-mode block.
`timescale 1ns/1ps
module testbench;
  import sclk_pkg::*;
  logic sys_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rd_q;
  logic power_down_pin = 1'b0, pkt_valid = 1'b0, pkt_accept, pkt_reject;
  logic [2:0] mode_strap = 3'h0;
  logic [1:0] sensor_format = 2'h0;
  logic [5:0] pkt_data_type = 6'h00;
  logic [3:0] gap = 4'h2;
  logic fc_tick, sensor_clk_out, sensor_clk_en;
  sclk_plan_t clock_plan;
  int n_errors = 0, total_checks = 0;

  // Clock at 10 MHz.
  always #50 sys_clk = ~sys_clk;

  sclk_link_peer peer (.sys_clk(sys_clk), .srst(srst), .gap(gap), .fc_tick(fc_tick));
  sclk_mode_ctrl dut (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .power_down_pin(power_down_pin),
    .mode_strap(mode_strap), .fc_tick(fc_tick), .sensor_format(sensor_format),
    .pkt_data_type(pkt_data_type), .pkt_valid(pkt_valid), .pkt_accept(pkt_accept),
    .pkt_reject(pkt_reject), .clock_plan(clock_plan), .sensor_clk_out(sensor_clk_out),
    .sensor_clk_en(sensor_clk_en));

  // Compare and count.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Single-cycle register write.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    // Let the write settle before anyone looks at what it changed.
    #1;
  endtask

  // Read; data is sampled in the cycle after the strobe only.
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rd_q = reg_rdata;
  endtask

  // Reset values and an unmapped address.
  task automatic t_reset();
    rd(SCLK_OFS_MODE_SEL); chk(rd_q, 8'h00);
    rd(SCLK_OFS_PLL_M); chk(rd_q, 8'h01);
    rd(SCLK_OFS_PLL_N); chk(rd_q, 8'h01);
    rd(SCLK_OFS_DT_MATCH); chk(rd_q, 8'h00);
    rd(8'hFF); chk(rd_q, 8'h00);
    chk(8'(clock_plan.src), 8'(SCLK_SRC_BACK_CHANNEL));
    $display("test reset done");
  endtask

  // Each strap code is caught when the settle window after the pin's rising edge ends; writes stay ignored.
  task automatic t_strap();
    logic [2:0] codes [4];
    codes = '{3'h0, 3'h2, 3'h3, 3'h5};
    foreach (codes[i]) begin
      @(posedge sys_clk) power_down_pin <= 1'b0;
      mode_strap <= codes[i];
      @(posedge sys_clk) power_down_pin <= 1'b1;
      repeat (5) @(posedge sys_clk);
      wr(SCLK_OFS_MODE_SEL, 8'h07);
      rd(SCLK_OFS_MODE_SEL); chk(rd_q, 8'(codes[i]));
      chk(8'(clock_plan.src), codes[i] == 3'h0 ? 8'(SCLK_SRC_BACK_CHANNEL) :
        codes[i] == 3'h3 ? 8'(SCLK_SRC_OSCILLATOR) : 8'(SCLK_SRC_EXT_CLOCK));
      chk(8'(sensor_clk_en), 8'(codes[i] != 3'h3));
    end
    $display("test strap done");
  endtask

  // Override enables writes; rate table for the external, oscillator and legacy modes and the input divider.
  task automatic t_override();
    wr(SCLK_OFS_MODE_SEL, 8'h10);
    wr(SCLK_OFS_MODE_SEL, 8'h12);
    wr(SCLK_OFS_OSC_CTRL, 8'h01);
    chk(clock_plan.fwd_mul, 8'h28);
    wr(SCLK_OFS_OSC_CTRL, 8'h08);
    chk(clock_plan.fwd_mul, 8'h50);
    wr(SCLK_OFS_MODE_SEL, 8'h13);
    chk(8'(clock_plan.osc_fast), 8'h01);
    chk(clock_plan.fwd_mul, 8'h50);
    wr(SCLK_OFS_MODE_SEL, 8'h15);
    rd(SCLK_OFS_MODE_SEL); chk(rd_q, 8'h15);
    chk(clock_plan.fwd_mul, 8'h1C);
    chk(clock_plan.bw_mul, 8'h14);
    chk(8'(clock_plan.bw_mul < clock_plan.fwd_mul), 8'h01);
    $display("test override done");
  endtask

  // One packet beat; accept and reject are combinational.
  task automatic pk(input logic [1:0] f, input logic [5:0] t, input logic [1:0] exp);
    @(posedge sys_clk);
    sensor_format <= f;
    pkt_data_type <= t;
    pkt_valid <= 1'b1;
    #1 chk(8'({pkt_accept, pkt_reject}), 8'(exp));
  endtask

  // Legacy-mode packet filtering, then a plain mode.
  task automatic t_packets();
    pk(2'h2, 6'h2A, 2'h1);
    pk(2'h0, 6'h2A, 2'h2);
    pk(2'h1, 6'h2A, 2'h2);
    wr(SCLK_OFS_FMT_OVR, 8'h03);
    pk(2'h2, 6'h2A, 2'h2);
    wr(SCLK_OFS_FMT_OVR, 8'h00);
    wr(SCLK_OFS_DT_MATCH, 8'hAA);
    pk(2'h2, 6'h2A, 2'h2);
    pk(2'h2, 6'h2B, 2'h1);
    wr(SCLK_OFS_MODE_SEL, 8'h10);
    pk(2'h2, 6'h2B, 2'h2);
    @(posedge sys_clk) pkt_valid <= 1'b0;
    $display("test packets done");
  endtask

  // Count sensor clock rising edges over a window.
  task automatic count_rises(input int cyc, output int n);
    logic prev;
    n = 0;
    prev = sensor_clk_out;
    repeat (cyc) begin
      @(posedge sys_clk) #1;
      if (sensor_clk_out && !prev) n++;
      prev = sensor_clk_out;
    end
  endtask

  // Tick every 2 cycles, M=N=1: divider 4 gives period 8, divider 8 period 16.
  task automatic t_clkout();
    int n;
    count_rises(160, n);
    chk(8'(n >= 18 && n <= 22), 8'h01);
    wr(SCLK_OFS_PLL_M, 8'h41);
    count_rises(160, n);
    chk(8'(n >= 8 && n <= 12), 8'h01);
    wr(SCLK_OFS_MODE_SEL, 8'h13);
    count_rises(80, n);
    chk(8'(n), 8'h00);
    rd(SCLK_OFS_STATUS); chk(rd_q, 8'h04);
    $display("test clkout done");
  endtask

  // Prints counts and verdict, then stops.
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    t_reset();
    t_strap();
    t_override();
    t_packets();
    t_clkout();
    print_verdict();
  end

  // Watchdog well beyond the expected run of about 500 cycles.
  initial begin
    #(100 * 5000);
    n_errors++;
    print_verdict();
  end
endmodule

bind sclk_mode_ctrl sclk_mode_props u_props (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .power_down_pin(power_down_pin), .pkt_valid(pkt_valid),
  .pkt_accept(pkt_accept), .clock_plan(clock_plan), .sensor_clk_en(sensor_clk_en));
